//--- design/sfq_pkg.sv
/*
 * Constants, opcodes, timing and state encoding for the serial flash
 * command sequencer. Assumes a 20 MHz core clock and a host in SPI mode 0 or 3.
 */
`default_nettype none

package sfq_pkg;

   // Opcodes
   localparam logic [7:0] OPC_OTP_PROG = 8'h9B;
   localparam logic [7:0] OPC_OTP_READ = 8'h77;
   localparam logic [7:0] OPC_XFER_B1 = 8'h53;
   localparam logic [7:0] OPC_XFER_B2 = 8'h55;
   localparam logic [7:0] OPC_COMP_B1 = 8'h60;
   localparam logic [7:0] OPC_COMP_B2 = 8'h61;
   localparam logic [7:0] OPC_REWR_B1 = 8'h58;
   localparam logic [7:0] OPC_REWR_B2 = 8'h59;
   localparam logic [7:0] OPC_STATUS = 8'hD7;

   // Frame layout, in whole bytes after chip select falls
   localparam logic [7:0] CMD_HDR_BYTES = 8'h04;
   localparam logic [7:0] STATUS_HDR_BYTES = 8'h01;
   localparam logic [7:0] BYTE_CNT_MAX = 8'hFF;

   // Page index position inside the 24-bit address
   localparam int PAGE_W = 13;
   localparam int PG_STD_LSB = 10;
   localparam int PG_BIN_LSB = 9;

   // Identity register
   localparam int OTP_USER_BYTES = 64;
   localparam logic [7:0] OTP_ERASED = 8'hFF;

   // Status byte fields; density code value is arbitrary
   localparam logic [3:0] DENSITY_CODE = 4'h0;
   localparam logic STAT_PROTECT = 1'b0;

   // Self-timed durations in microseconds, and cycle counts
   localparam int CLK_MHZ = 20;
   localparam int T_XFER_US = 200;
   localparam int T_COMP_US = 200;
   localparam int T_REWR_US = 35000;
   localparam int T_OTP_US = 5000;
   localparam logic [19:0] XFER_CYC = 20'(T_XFER_US * CLK_MHZ);
   localparam logic [19:0] COMP_CYC = 20'(T_COMP_US * CLK_MHZ);
   localparam logic [19:0] TMR_ZERO = 20'h0_0000;
   localparam logic [19:0] TMR_ONE = 20'h0_0001;

   // Array command codes
   localparam logic [1:0] ARR_XFER = 2'h0;
   localparam logic [1:0] ARR_COMP = 2'h1;
   localparam logic [1:0] ARR_REWR = 2'h2;
   localparam logic [1:0] ARR_OTPBUF = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_XFER = 5'b0_0010,
      ST_COMP = 5'b0_0100,
      ST_REWR = 5'b0_1000,
      ST_OTPP = 5'b1_0000
   } sfq_state_e;

endpackage

`default_nettype wire

//--- design/sfq_seq.sv
/*
 * Serial flash command sequencer: identity register program/read, page to
 * buffer transfer, compare, auto rewrite and status polling.
 * Assumes the host SPI pins are asynchronous to ref_clk and the serial clock
 * is at most a quarter of ref_clk; the flash array sits behind arr_cmd_* on
 * the ref_clk domain and answers compares on arr_resp_*.
 */
// Functional notes
// - Identity register is 128 bytes: 0-63 user, 64-127 fixed factory value.
// - User area programs once; every later program attempt is ignored; here reset_n clears the lock and sets the user area back to FF.
// - User area is written directly with no erase step.
// - Chip select rise starts program; busy for the program time.
// - Bytes not supplied before chip select rises hold undefined values.
// - Data byte index wraps after 64, byte 65 goes to location 0.
// - Identity program uses buffer 1, overwriting its contents.
// - Opcode 77 plus three dummy bytes then streams identity bytes out.
// - Past the last byte output is undefined; chip select high floats output.
// - Transfer opcodes 53 (buffer 1) or 55 (buffer 2) plus three address bytes.
// - 528-byte mode: 1 ignored bit, 13-bit page, 10 ignored bits.
// - 512-byte mode: 2 ignored bits, page in address bits 21..9, 9 ignored.
// - Transfer starts at chip select rise, busy for page load time.
// - Compare opcodes 60 or 61 plus three address bytes, same format.
// - Compare starts at chip select rise, busy, then updates status bit 6.
// - Compare flag is 0 on exact match, 1 if any bit differs.
// - Rewrite opcodes 58 or 59 plus three address bytes.
// - Rewrite loads page to buffer then programs it back, busy for rewrite time.
// - Opcode D7 returns status byte repeatedly, msb first.
// - Status bit 7 is 1 when idle, 0 while a timed operation runs.
// - Status bit 0 is 1 in 512-byte mode, selects the address format.
`timescale 1ns/1ns
`default_nettype none

module sfq_seq #(
   parameter logic [19:0] REWR_CYC = 20'(sfq_pkg::T_REWR_US * sfq_pkg::CLK_MHZ),
   parameter logic [19:0] OTP_CYC = 20'(sfq_pkg::T_OTP_US * sfq_pkg::CLK_MHZ),
   // Arbitrary per-device value, byte at location 64 in bits 7:0
   parameter logic [511:0] FACTORY_UID = {64{8'hA5}}
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic page_bin_mode,
   output logic so,
   output logic so_oe,
   output logic rdy_busy,
   output logic arr_cmd_valid,
   input wire logic arr_cmd_ready,
   output logic [1:0] arr_cmd_op,
   output logic arr_cmd_buf,
   output logic [12:0] arr_cmd_page,
   input wire logic arr_resp_valid,
   input wire logic arr_resp_mismatch
);
   import sfq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the third stage only feeds edge detection
   logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
   logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
   logic si_s1_ff, si_s2_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
         cs_s3_ff <= 1'b1;
         sck_s1_ff <= 1'b0;
         sck_s2_ff <= 1'b0;
         sck_s3_ff <= 1'b0;
         si_s1_ff <= 1'b0;
         si_s2_ff <= 1'b0;
      end else begin
         cs_s1_ff <= cs_n;
         cs_s2_ff <= cs_s1_ff;
         cs_s3_ff <= cs_s2_ff;
         sck_s1_ff <= sck;
         sck_s2_ff <= sck_s1_ff;
         sck_s3_ff <= sck_s2_ff;
         si_s1_ff <= si;
         si_s2_ff <= si_s1_ff;
      end
   end

   wire sel = ~cs_s2_ff;
   wire sck_rise = sel & sck_s2_ff & ~sck_s3_ff;
   wire sck_fall = sel & ~sck_s2_ff & sck_s3_ff;
   wire cs_rise = cs_s2_ff & ~cs_s3_ff;

   ////////////////////////////////////////////////////////////////////////
   // Serial input framing
   logic [2:0] bit_cnt_ff;
   logic [6:0] shreg_ff;
   logic [7:0] byte_cnt_ff;
   logic [7:0] opc_ff;
   logic [23:0] addr_ff;
   logic hdr_zero_ff;
   logic [6:0] data_idx_ff;

   wire [7:0] rx_byte = {shreg_ff, si_s2_ff};
   wire byte_done = sck_rise & (bit_cnt_ff == 3'd7);
   wire in_data = byte_cnt_ff >= CMD_HDR_BYTES;
   wire in_addr = (byte_cnt_ff != 8'h00) & ~in_data;
   wire [7:0] nxt_byte_cnt = (byte_cnt_ff == BYTE_CNT_MAX) ? byte_cnt_ff : byte_cnt_ff + 8'h01;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_ff <= 3'd0;
         shreg_ff <= 7'h00;
         byte_cnt_ff <= 8'h00;
         opc_ff <= 8'h00;
         addr_ff <= 24'h00_0000;
         hdr_zero_ff <= 1'b1;
         data_idx_ff <= 7'h00;
      end else if (!sel) begin
         bit_cnt_ff <= 3'd0;
         byte_cnt_ff <= 8'h00;
         hdr_zero_ff <= 1'b1;
         data_idx_ff <= 7'h00;
      end else if (sck_rise) begin
         bit_cnt_ff <= bit_cnt_ff + 3'd1;
         shreg_ff <= rx_byte[6:0];
         if (byte_done) begin
            byte_cnt_ff <= nxt_byte_cnt;
            if (byte_cnt_ff == 8'h00) begin
               opc_ff <= rx_byte;
            end
            if (in_addr) begin
               addr_ff <= {addr_ff[15:0], rx_byte};
               hdr_zero_ff <= hdr_zero_ff & (rx_byte == 8'h00);
            end
            if (in_data) begin
               data_idx_ff <= data_idx_ff + 7'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   sfq_state_e state_ff, nxt_state, start_st;
   logic [19:0] tmr_ff;
   logic otp_locked_ff;
   logic cmp_ff, mis_ff;
   logic rdy_busy_ff;
   logic a_vld_ff, b_vld_ff;
   logic [15:0] a_word_ff, b_word_ff;

   wire idle = state_ff == ST_IDLE;
   wire in_ready = ~b_vld_ff;
   wire op_xfer = (opc_ff == OPC_XFER_B1) | (opc_ff == OPC_XFER_B2);
   wire op_comp = (opc_ff == OPC_COMP_B1) | (opc_ff == OPC_COMP_B2);
   wire op_rewr = (opc_ff == OPC_REWR_B1) | (opc_ff == OPC_REWR_B2);
   wire op_otp = (opc_ff == OPC_OTP_PROG) & hdr_zero_ff;
   wire buf2 = (opc_ff == OPC_XFER_B2) | (opc_ff == OPC_COMP_B2) | (opc_ff == OPC_REWR_B2);
   wire op_page = op_xfer | op_comp | op_rewr;
   // Commands arriving while busy or while the array queue is full are dropped
   wire go = cs_rise & idle & in_ready & in_data;
   wire start_page = go & op_page;
   wire start_otp = go & op_otp & ~otp_locked_ff;
   wire start_any = start_page | start_otp;
   wire [12:0] page_sel = page_bin_mode ? addr_ff[PG_BIN_LSB +: PAGE_W]
                                        : addr_ff[PG_STD_LSB +: PAGE_W];
   wire [19:0] start_cyc = op_xfer ? XFER_CYC : op_comp ? COMP_CYC : op_rewr ? REWR_CYC : OTP_CYC;
   wire [1:0] start_aop = op_xfer ? ARR_XFER : op_comp ? ARR_COMP : op_rewr ? ARR_REWR : ARR_OTPBUF;
   // Identity programming reuses buffer 1 of the array, so the array is told
   wire [15:0] push_word = op_page ? {start_aop, buf2, page_sel} : {ARR_OTPBUF, 14'h0000};
   // Cast keeps the enum type through the selection for strict front ends
   assign start_st = sfq_state_e'(op_xfer ? ST_XFER : op_comp ? ST_COMP
                                  : op_rewr ? ST_REWR : ST_OTPP);

   ////////////////////////////////////////////////////////////////////////
   // Self-timed operation sequencer
   wire tmr_zero = tmr_ff == TMR_ZERO;
   wire op_end = ~idle & tmr_zero;
   wire [19:0] nxt_tmr = start_any ? start_cyc - TMR_ONE : op_end ? tmr_ff : tmr_ff - TMR_ONE;
   wire otp_commit = (state_ff == ST_OTPP) & tmr_zero;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start_any) nxt_state = start_st;
         end
         ST_XFER, ST_COMP, ST_REWR, ST_OTPP: begin
            if (tmr_zero) nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         tmr_ff <= TMR_ZERO;
      end else begin
         state_ff <= nxt_state;
         tmr_ff <= idle & ~start_any ? TMR_ZERO : nxt_tmr;
      end
   end

   // Array reports the compare outcome; it is published only when the op ends
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mis_ff <= 1'b0;
         cmp_ff <= 1'b0;
      end else begin
         mis_ff <= arr_resp_valid ? arr_resp_mismatch : mis_ff;
         cmp_ff <= ((state_ff == ST_COMP) & tmr_zero) ? mis_ff : cmp_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Identity register storage
   logic [7:0] stg_mem [0:OTP_USER_BYTES-1];
   logic [7:0] user_ff [0:OTP_USER_BYTES-1];

   wire stg_we = byte_done & in_data & (opc_ff == OPC_OTP_PROG) & idle;

   // Staging is not cleared, so unsent bytes commit whatever it held
   always_ff @(posedge ref_clk) begin
      if (stg_we) begin
         stg_mem[data_idx_ff[5:0]] <= rx_byte;
      end
   end

   // Lock flag lives in flops here, so a reset reopens the user area
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         otp_locked_ff <= 1'b0;
      end else if (otp_commit) begin
         otp_locked_ff <= 1'b1;
      end
   end

   genvar gi;
   for (gi = 0; gi < OTP_USER_BYTES; gi = gi + 1) begin : g_user
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            user_ff[gi] <= OTP_ERASED;
         end else if (otp_commit) begin
            user_ff[gi] <= stg_mem[gi];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output
   logic so_ff, so_oe_ff;

   // Index past 127 wraps, which is one acceptable undefined pattern
   wire [7:0] sec_byte = data_idx_ff[6] ? FACTORY_UID[{data_idx_ff[5:0], 3'b000} +: 8]
                                        : user_ff[data_idx_ff[5:0]];
   wire [7:0] status_byte = {rdy_busy_ff, cmp_ff, DENSITY_CODE, STAT_PROTECT, page_bin_mode};
   wire tx_status = (opc_ff == OPC_STATUS) & (byte_cnt_ff >= STATUS_HDR_BYTES);
   wire tx_otp = (opc_ff == OPC_OTP_READ) & in_data;
   wire [7:0] tx_byte = tx_otp ? sec_byte : status_byte;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         so_ff <= 1'b0;
         so_oe_ff <= 1'b0;
      end else if (!sel) begin
         so_ff <= 1'b0;
         so_oe_ff <= 1'b0;
      end else if (sck_fall & (tx_status | tx_otp)) begin
         so_ff <= tx_byte[3'd7 - bit_cnt_ff];
         so_oe_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-entry array command buffer; a full buffer holds the device busy
   wire pop = a_vld_ff & arr_cmd_ready;
   wire a_free = ~a_vld_ff | pop;
   wire nxt_a_vld = a_free ? (b_vld_ff | start_any) : 1'b1;
   wire nxt_b_vld = a_free ? (b_vld_ff & start_any) : (b_vld_ff | start_any);
   wire [15:0] nxt_a_word = ~a_free ? a_word_ff : b_vld_ff ? b_word_ff : push_word;
   wire b_load = start_any & (a_free ? b_vld_ff : ~b_vld_ff);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         a_vld_ff <= 1'b0;
         b_vld_ff <= 1'b0;
         a_word_ff <= 16'h0000;
         b_word_ff <= 16'h0000;
         rdy_busy_ff <= 1'b1;
      end else begin
         a_vld_ff <= nxt_a_vld;
         b_vld_ff <= nxt_b_vld;
         a_word_ff <= nxt_a_word;
         b_word_ff <= b_load ? push_word : b_word_ff;
         rdy_busy_ff <= (nxt_state == ST_IDLE) & ~nxt_b_vld;
      end
   end

   assign so = so_ff;
   assign so_oe = so_oe_ff;
   assign rdy_busy = rdy_busy_ff;
   assign arr_cmd_valid = a_vld_ff;
   assign arr_cmd_op = a_word_ff[15:14];
   assign arr_cmd_buf = a_word_ff[13];
   assign arr_cmd_page = a_word_ff[12:0];

endmodule // sfq_seq

`default_nettype wire

//--- design/placeholder_none.sv
`default_nettype wire

//--- bench/sfq_seq_assertions.sv
/* Port checker for the serial flash sequencer.
   Assumes one ref_clk domain with active-low asynchronous reset_n. */
`timescale 1ns/1ns
`default_nettype none
module sfq_seq_assertions (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic so,
   input wire logic so_oe,
   input wire logic rdy_busy,
   input wire logic arr_cmd_valid,
   input wire logic arr_cmd_ready,
   input wire logic [1:0] arr_cmd_op,
   input wire logic arr_cmd_buf,
   input wire logic [12:0] arr_cmd_page
);
   import sfq_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // Sync delay plus release time is under eight cycles
   a_float_idle: assert property (cs_n [*8] |-> !so_oe)
      else $error("serial output still driven after chip select high");
   a_quiet_line: assert property (!so_oe |-> !so)
      else $error("serial output not low while released");
   a_drive_frame: assert property ($rose(so_oe) |-> !cs_n)
      else $error("serial output enabled outside a frame");
   a_cmd_busy: assert property (arr_cmd_valid |-> !rdy_busy)
      else $error("array command shown while ready");
   a_cmd_holds: assert property (arr_cmd_valid && !arr_cmd_ready |=>
      arr_cmd_valid && $stable({arr_cmd_op, arr_cmd_buf, arr_cmd_page}))
      else $error("array command changed before acceptance");
   a_otp_fields: assert property (arr_cmd_valid && arr_cmd_op == ARR_OTPBUF |->
      !arr_cmd_buf && arr_cmd_page == 13'h0000)
      else $error("identity program command fields not zero");
   a_busy_cs: assert property ($fell(rdy_busy) |-> cs_n)
      else $error("busy began while chip select low");
   a_busy_min: assert property ($fell(rdy_busy) |=> !rdy_busy [*8])
      else $error("busy ended too early");
   c_read: cover property ($rose(so_oe));
   c_take: cover property (arr_cmd_valid && arr_cmd_ready);
   c_done: cover property ($rose(rdy_busy));
endmodule // sfq_seq_assertions

bind sfq_seq sfq_seq_assertions sfq_seq_assertions_i (.ref_clk(ref_clk), .reset_n(reset_n),
   .cs_n(cs_n), .so(so), .so_oe(so_oe), .rdy_busy(rdy_busy), .arr_cmd_valid(arr_cmd_valid),
   .arr_cmd_ready(arr_cmd_ready), .arr_cmd_op(arr_cmd_op), .arr_cmd_buf(arr_cmd_buf),
   .arr_cmd_page(arr_cmd_page));
`default_nettype wire

//--- bench/sfq_host_model.sv
/* Host serial controller model, mode 0, clock 400 ns.
   Assumes ref_clk at 50 ns; changes pins only at its falling edge. */
`timescale 1ns/1ns
`default_nettype none
module sfq_host_model (
   input wire logic ref_clk,
   input wire logic so,
   output var logic cs_n,
   output var logic sck,
   output var logic si
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   task automatic open_f();
      @(negedge ref_clk);
      cs_n = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   // Output taken late in the high phase, well clear of the next change
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         repeat (4) @(negedge ref_clk);
         sck = 1'b1;
         repeat (4) @(negedge ref_clk);
         rx[i] = so;
         sck = 1'b0;
      end
   endtask
   // Clock stays low between frames; released data line flips
   task automatic close_f();
      repeat (4) @(negedge ref_clk);
      cs_n = 1'b1;
      si = ~si;
      repeat (12) @(negedge ref_clk);
   endtask
endmodule // sfq_host_model
`default_nettype wire

//--- bench/sfq_seq_tb_top.sv
/* Self-checking bench for the serial flash sequencer.
   Assumes the host model drives the serial pins; the bench plays the array. */
`timescale 1ns/1ns
`default_nettype none
module sfq_seq_tb_top;
   import sfq_pkg::*;
   // Arbitrary unique value for the factory half
   localparam logic [511:0] UID = {32{16'h3C96}};
   logic ref_clk, reset_n, cs_n, sck, si, page_bin_mode, so, so_oe, rdy_busy;
   logic arr_cmd_valid, arr_cmd_ready, arr_cmd_buf, mism, cmp_exp, resp_vld;
   logic [1:0] arr_cmd_op;
   logic [12:0] arr_cmd_page;
   logic [7:0] rx;
   int bad_count, compares;
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   sfq_host_model sfq_host_model_i (.ref_clk(ref_clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
   sfq_seq #(.REWR_CYC(20'h0_00C8), .OTP_CYC(20'h0_0028), .FACTORY_UID(UID)) sfq_seq_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
      .page_bin_mode(page_bin_mode), .so(so), .so_oe(so_oe), .rdy_busy(rdy_busy),
      .arr_cmd_valid(arr_cmd_valid), .arr_cmd_ready(arr_cmd_ready), .arr_cmd_op(arr_cmd_op),
      .arr_cmd_buf(arr_cmd_buf), .arr_cmd_page(arr_cmd_page), .arr_resp_valid(resp_vld),
      .arr_resp_mismatch(mism));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Bounded wait for ready (1) or for an array command (0)
   task automatic wait_for(input bit want_rdy);
      int k;
      k = 0;
      while ((want_rdy ? rdy_busy : arr_cmd_valid) !== 1'b1 && k < 9000) begin
         @(negedge ref_clk);
         k++;
      end
      if (k >= 9000) begin
         bad_count++;
         $display("mismatch wait_for expected %0d seen timeout", want_rdy);
      end
   endtask
   task automatic cmd4(input logic [7:0] opc, input logic [23:0] a);
      sfq_host_model_i.open_f();
      sfq_host_model_i.xb(opc, rx);
      sfq_host_model_i.xb(a[23:16], rx);
      sfq_host_model_i.xb(a[15:8], rx);
      sfq_host_model_i.xb(a[7:0], rx);
   endtask
   // Second byte proves the status byte repeats
   task automatic stat(input logic rdy);
      sfq_host_model_i.open_f();
      sfq_host_model_i.xb(OPC_STATUS, rx);
      sfq_host_model_i.xb(8'h00, rx);
      sfq_host_model_i.xb(8'h00, rx);
      sfq_host_model_i.close_f();
      chk("status", {24'h0, rdy, cmp_exp, DENSITY_CODE, STAT_PROTECT, page_bin_mode},
         {24'h0, rx});
   endtask
   task automatic run_op(input logic [7:0] opc, input logic bin, input logic [12:0] pg,
      input logic [1:0] op, input logic bf, input logic m);
      page_bin_mode = bin;
      mism = m;
      arr_cmd_ready = 1'b0;
      cmd4(opc, bin ? {2'b00, pg, 9'h000} : {1'b0, pg, 10'h000});
      sfq_host_model_i.close_f();
      wait_for(1'b0);
      chk("command", {16'h0, op, bf, pg}, {16'h0, arr_cmd_op, arr_cmd_buf, arr_cmd_page});
      chk("busy", 32'h0, {31'h0, rdy_busy});
      repeat (3) @(negedge ref_clk);
      arr_cmd_ready = 1'b1;
      // Array answers once; the result line then moves with no valid beside it
      resp_vld = 1'b1;
      @(negedge ref_clk);
      resp_vld = 1'b0;
      mism = ~m;
      // Rewrite is shortened too far for a status frame inside it
      if (op != ARR_REWR) begin
         stat(1'b0);
         // Stalled array keeps any wrongly accepted command visible
         arr_cmd_ready = 1'b0;
         cmd4(OPC_XFER_B2, 24'h00_0000);
         sfq_host_model_i.close_f();
         chk("refused", 32'h0, {31'h0, arr_cmd_valid});
         arr_cmd_ready = 1'b1;
      end
      wait_for(1'b1);
      if (op == ARR_COMP) cmp_exp = m;
      stat(1'b1);
   endtask
   task automatic t_status();
      page_bin_mode = 1'b0;
      stat(1'b1);
      page_bin_mode = 1'b1;
      stat(1'b1);
   endtask
   task automatic t_pages();
      run_op(OPC_XFER_B1, 1'b0, 13'h1555, ARR_XFER, 1'b0, 1'b0);
      run_op(OPC_XFER_B2, 1'b1, 13'h0AAA, ARR_XFER, 1'b1, 1'b0);
      run_op(OPC_COMP_B1, 1'b0, 13'h1FFF, ARR_COMP, 1'b0, 1'b1);
      run_op(OPC_COMP_B2, 1'b1, 13'h0000, ARR_COMP, 1'b1, 1'b0);
      run_op(OPC_REWR_B1, 1'b0, 13'h0F0F, ARR_REWR, 1'b0, 1'b1);
      run_op(OPC_REWR_B2, 1'b1, 13'h10F0, ARR_REWR, 1'b1, 1'b0);
   endtask
   task automatic otp_prog(input logic [7:0] x, input int n);
      cmd4(OPC_OTP_PROG, 24'h00_0000);
      for (int i = 0; i < n; i++) sfq_host_model_i.xb(i == 64 ? 8'hC3 : 8'(i) ^ x, rx);
      sfq_host_model_i.close_f();
   endtask
   task automatic otp_read();
      logic [7:0] e;
      cmd4(OPC_OTP_READ, 24'h00_0000);
      for (int i = 0; i < 128; i++) begin
         sfq_host_model_i.xb(8'h00, rx);
         e = i == 0 ? 8'hC3 : i < 64 ? 8'(i) ^ 8'h3C : UID[8*(i-64) +: 8];
         chk("identity byte", {24'h0, e}, {24'h0, rx});
      end
      sfq_host_model_i.close_f();
   endtask
   task automatic t_otp();
      arr_cmd_ready = 1'b0;
      otp_prog(8'h3C, 65);
      wait_for(1'b0);
      chk("buffer use", {30'h0, ARR_OTPBUF}, {30'h0, arr_cmd_op});
      arr_cmd_ready = 1'b1;
      wait_for(1'b1);
      otp_read();
      otp_prog(8'hFF, 64);
      chk("locked busy", 32'h1, {31'h0, rdy_busy});
      otp_read();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      page_bin_mode = 1'b0;
      arr_cmd_ready = 1'b1;
      mism = 1'b0;
      resp_vld = 1'b0;
      cmp_exp = 1'b0;
      bad_count = 0;
      compares = 0;
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      t_status();
      t_pages();
      t_otp();
      finish_test();
   end
   // Whole run is near 45500 cycles
   initial begin
      repeat (80000) @(posedge ref_clk);
      bad_count++;
      $display("mismatch watchdog expected finish seen timeout");
      finish_test();
   end
endmodule // sfq_seq_tb_top
`default_nettype wire
